// ---- design/enc_frame_defs.vh ----
// frame offsets, field positions and reset values for the safety process data framer
// assumes a byte-serial frame port driven by the safety communication layer
`ifndef ENC_FRAME_DEFS_VH
`define ENC_FRAME_DEFS_VH

// ==========================================
// input frame (device to host) byte offsets
`define IN_CAM_OFS 4'h0
`define IN_STATUS_OFS 4'h2
`define IN_SPEED_OFS 4'h4
`define IN_TURN_OFS 4'h6
`define IN_POS_OFS 4'h8
`define IN_SAFE_STATUS_OFS 4'ha
`define IN_CHECK_OFS 4'hb
`define IN_FRAME_LEN 4'he

// ==========================================
// output frame (host to device) byte offsets
`define OUT_CTRL1_OFS 4'h0
`define OUT_CTRL2_OFS 4'h2
`define OUT_PRESET_TURN_OFS 4'h4
`define OUT_PRESET_POS_OFS 4'h6
`define OUT_SAFE_CONTROL_OFS 4'h8
`define OUT_CHECK_OFS 4'h9
`define OUT_FRAME_LEN 4'hc

// ==========================================
// field positions
`define CAM_OVERFLOW_BIT 0
`define STATUS_PRESET_BIT 0
`define STATUS_ERROR_BIT 15
`define SAFE_STATUS_DONE_BIT 0
`define CTRL1_PRESET_REQ_BIT 0
`define CTRL2_DIR_BACKWARD_BIT 0

// ==========================================
// speed limits and reset values
`define SPEED_MAX 16'h7fff
`define SPEED_MIN 16'h8000
`define WORD_RESET 16'h0000
`define BYTE_RESET 8'h00
`define CHECK_RESET 24'h000000

`endif

// ---- design/speed_sat.v ----
// signed speed saturation to the 16-bit display range
// assumes a wide signed increment count per integration interval, same clock
`include "enc_frame_defs.vh"
module speed_sat
(
    // clock and reset
    input wire I_CLK,
    input wire I_RST_B,
    // raw count and direction
    input wire signed [23:0] i_count,
    input wire i_backward,
    // saturated speed
    output reg [15:0] o_speed,
    output reg o_overflow
);

reg signed [24:0] signed_count;

always @*
begin
    signed_count = i_backward ? -{i_count[23], i_count} : {i_count[23], i_count};
end

always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        o_speed <= `WORD_RESET;
        o_overflow <= 1'b0;
    end
    else if (signed_count > 25'sd32767)
    begin
        o_speed <= `SPEED_MAX;
        o_overflow <= 1'b1;
    end
    else if (signed_count < -25'sd32768)
    begin
        o_speed <= `SPEED_MIN;
        o_overflow <= 1'b1;
    end
    else
    begin
        o_speed <= signed_count[15:0];
        o_overflow <= 1'b0;
    end
end

endmodule // speed_sat

// ---- design/enc_frame.v ----
// safety process data framer: builds the input frame, parses the output frame
// assumes byte streams from and to the safety layer on the same clock; crc is external
// limitation: crc bytes pass through unchecked in both directions
`include "enc_frame_defs.vh"

module enc_frame
(
    // clock and reset
    input wire I_CLK,
    input wire I_RST_B,
    // measurement inputs
    input wire signed [23:0] I_INCR_COUNT,
    input wire [15:0] I_TURN_COUNT,
    input wire [15:0] I_IN_TURN_POS,
    input wire I_STANDSTILL_OK,
    // parameter enable variable from the host data block
    input wire I_PARAM_ENABLE,
    // preset engine handshake
    output wire O_PRESET_START,
    output reg [15:0] O_PRESET_TURN,
    output reg [15:0] O_PRESET_POS,
    input wire I_PRESET_DONE,
    // output frame byte stream from the host
    input wire I_RX_VALID,
    input wire I_RX_SOF,
    input wire [7:0] I_RX_DATA,
    // received control words
    output reg [15:0] O_CTRL_ONE,
    output reg [15:0] O_CTRL_TWO,
    output reg [7:0] O_SAFE_CONTROL,
    output reg [23:0] O_RX_CHECK,
    output reg O_RX_FRAME_DONE,
    // input frame byte stream to the host
    input wire I_TX_START,
    input wire [23:0] I_TX_CHECK,
    input wire I_TX_READY,
    output wire O_TX_VALID,
    output reg [7:0] O_TX_DATA,
    output wire O_TX_LAST
);

// ==========================================
// speed path
wire [15:0] speed_word;
wire overflow;
reg backward_reg;

// the raw count is already the sum of increments over one integration interval
speed_sat u_speed_sat
(
    .I_CLK(I_CLK),
    .I_RST_B(I_RST_B),
    .i_count(I_INCR_COUNT),
    .i_backward(backward_reg),
    .o_speed(speed_word),
    .o_overflow(overflow)
);

// direction follows control word two one cycle late, off the parser's path
always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
        backward_reg <= 1'b0;
    else
        backward_reg <= O_CTRL_TWO[`CTRL2_DIR_BACKWARD_BIT];
end

// ==========================================
// preset handshake
localparam P_IDLE = 2'd0;
localparam P_BUSY = 2'd1;
localparam P_ERROR = 2'd2;
localparam P_DONE = 2'd3;

reg [1:0] p_state_reg;
reg [1:0] p_state_next;
reg enable_d_reg;
reg req_d_reg;
reg preset_status_reg;
reg preset_error_reg;
reg done_flag_reg;
wire enable_rise;
wire ctrl_req;
wire req_rise;
wire preset_req;

assign ctrl_req = O_CTRL_ONE[`CTRL1_PRESET_REQ_BIT];
assign enable_rise = I_PARAM_ENABLE & ~enable_d_reg;
assign req_rise = ctrl_req & ~req_d_reg;
assign preset_req = enable_rise | req_rise;
assign O_PRESET_START = (p_state_reg == P_IDLE) && preset_req && I_STANDSTILL_OK;

// edge registers reset to the idle low level, so an enable still high when reset releases counts as a request
always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        enable_d_reg <= 1'b0;
        req_d_reg <= 1'b0;
    end
    else
    begin
        enable_d_reg <= I_PARAM_ENABLE;
        req_d_reg <= ctrl_req;
    end
end

always @*
begin
    p_state_next = p_state_reg;
    case (p_state_reg)
        P_IDLE:
        begin
            if (preset_req)
                p_state_next = I_STANDSTILL_OK ? P_BUSY : P_ERROR;
        end
        P_BUSY:
        begin
            if (I_PRESET_DONE)
                p_state_next = P_DONE;
        end
        P_ERROR:
        begin
            // error holds until the host withdraws both its enable and its control word one request
            if (!I_PARAM_ENABLE && !ctrl_req)
                p_state_next = P_IDLE;
        end
        P_DONE:
        begin
            // new requests wait until the host drops both request sources
            if (!I_PARAM_ENABLE && !ctrl_req)
                p_state_next = P_IDLE;
        end
        default:
            p_state_next = P_IDLE;
    endcase
end

always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        p_state_reg <= P_IDLE;
        preset_status_reg <= 1'b0;
        preset_error_reg <= 1'b0;
    end
    else
    begin
        p_state_reg <= p_state_next;
        // status bit rises with the request and drops when the preset completes
        preset_status_reg <= (p_state_next == P_BUSY);
        preset_error_reg <= (p_state_next == P_ERROR);
    end
end

// done flag stays until a new request; a completion beats a request in one cycle
always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
        done_flag_reg <= 1'b0;
    else if (p_state_reg == P_BUSY && I_PRESET_DONE)
        done_flag_reg <= 1'b1;
    else if (preset_req)
        done_flag_reg <= 1'b0;
end

// ==========================================
// output frame parser
reg [3:0] rx_idx_reg;
reg [7:0] rx_hi_reg;

always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        rx_idx_reg <= 4'h0;
        rx_hi_reg <= `BYTE_RESET;
        O_CTRL_ONE <= `WORD_RESET;
        O_CTRL_TWO <= `WORD_RESET;
        O_PRESET_TURN <= `WORD_RESET;
        O_PRESET_POS <= `WORD_RESET;
        O_SAFE_CONTROL <= `BYTE_RESET;
        O_RX_CHECK <= `CHECK_RESET;
        O_RX_FRAME_DONE <= 1'b0;
    end
    else
    begin
        O_RX_FRAME_DONE <= 1'b0;
        if (I_RX_VALID)
        begin
            // a start marker resynchronises the byte index to offset zero
            if (I_RX_SOF || rx_idx_reg >= `OUT_FRAME_LEN)
            begin
                rx_hi_reg <= I_RX_DATA;
                rx_idx_reg <= 4'h1;
            end
            else
            begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
                rx_hi_reg <= I_RX_DATA;
                // odd offsets 1 to 7 complete a word whose high byte came first
                case (rx_idx_reg)
                    `OUT_CTRL1_OFS + 4'h1: O_CTRL_ONE <= {rx_hi_reg, I_RX_DATA};
                    `OUT_CTRL2_OFS + 4'h1: O_CTRL_TWO <= {rx_hi_reg, I_RX_DATA};
                    `OUT_PRESET_TURN_OFS + 4'h1: O_PRESET_TURN <= {rx_hi_reg, I_RX_DATA};
                    `OUT_PRESET_POS_OFS + 4'h1: O_PRESET_POS <= {rx_hi_reg, I_RX_DATA};
                    `OUT_SAFE_CONTROL_OFS: O_SAFE_CONTROL <= I_RX_DATA;
                    `OUT_CHECK_OFS: O_RX_CHECK[23:16] <= I_RX_DATA;
                    `OUT_CHECK_OFS + 4'h1: O_RX_CHECK[15:8] <= I_RX_DATA;
                    `OUT_CHECK_OFS + 4'h2:
                    begin
                        O_RX_CHECK[7:0] <= I_RX_DATA;
                        O_RX_FRAME_DONE <= 1'b1;
                    end
                    default:
                        O_RX_CHECK <= O_RX_CHECK;
                endcase
            end
        end
    end
end

// ==========================================
// input frame builder
reg [15:0] cam_word;
reg [15:0] status_word;
reg [7:0] safe_status;
reg [111:0] tx_shadow_reg;
reg [3:0] tx_idx_reg;
reg tx_busy_reg;

// reserved bits are cleared first, then each flag is placed at its position
always @*
begin
    cam_word = `WORD_RESET;
    cam_word[`CAM_OVERFLOW_BIT] = overflow;
end

always @*
begin
    status_word = `WORD_RESET;
    status_word[`STATUS_PRESET_BIT] = preset_status_reg;
    status_word[`STATUS_ERROR_BIT] = preset_error_reg;
end

always @*
begin
    safe_status = `BYTE_RESET;
    safe_status[`SAFE_STATUS_DONE_BIT] = done_flag_reg;
end

assign O_TX_VALID = tx_busy_reg;
// last is decoded from the index, so it moves with the byte it marks
assign O_TX_LAST = tx_busy_reg && (tx_idx_reg == `IN_FRAME_LEN - 4'h1);

// the frame is snapshotted at start so all fields belong to one cycle
always @(posedge I_CLK or negedge I_RST_B)
begin
    if (!I_RST_B)
    begin
        tx_shadow_reg <= 112'h0;
        tx_idx_reg <= 4'h0;
        tx_busy_reg <= 1'b0;
        O_TX_DATA <= `BYTE_RESET;
    end
    else if (!tx_busy_reg)
    begin
        if (I_TX_START)
        begin
            // most significant byte of each word sits at the lower offset
            tx_shadow_reg <= {cam_word, status_word, speed_word, I_TURN_COUNT,
                              I_IN_TURN_POS, safe_status, I_TX_CHECK};
            O_TX_DATA <= cam_word[15:8];
            tx_idx_reg <= 4'h0;
            tx_busy_reg <= 1'b1;
        end
    end
    else if (I_TX_READY)
    begin
        if (tx_idx_reg == `IN_FRAME_LEN - 4'h1)
            tx_busy_reg <= 1'b0;
        else
        begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            O_TX_DATA <= tx_shadow_reg[103:96];
            tx_shadow_reg <= {tx_shadow_reg[103:0], 8'h00};
        end
    end
end

endmodule // enc_frame

// ---- verification/enc_frame_asserts.sv ----
// checker for the process data framer, watching the top ports only
// assumes one clock domain with the async active-low reset
module enc_frame_asserts
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // preset
    input wire logic I_STANDSTILL_OK,
    input wire logic I_PARAM_ENABLE,
    input wire logic O_PRESET_START,
    // output frame side
    input wire logic I_RX_VALID,
    input wire logic I_RX_SOF,
    input wire logic [7:0] I_RX_DATA,
    input wire logic [15:0] O_CTRL_ONE,
    input wire logic O_RX_FRAME_DONE,
    // input frame side
    input wire logic I_TX_START,
    input wire logic I_TX_READY,
    input wire logic O_TX_VALID,
    input wire logic [7:0] O_TX_DATA,
    input wire logic O_TX_LAST
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // ====================
    // bytes accepted so far in the current input frame
    logic [3:0] sent_reg;
    always @(posedge I_CLK or negedge I_RST_B)
        if (!I_RST_B)
            sent_reg <= 4'h0;
        else if (O_TX_VALID && I_TX_READY)
            sent_reg <= O_TX_LAST ? 4'h0 : sent_reg + 4'h1;
    a_tx_first_byte: assert property (!O_TX_VALID && I_TX_START |=> O_TX_VALID && O_TX_DATA == 8'h00)
        else $error("bad first byte");
    a_tx_byte_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
        else $error("byte not held");
    a_tx_last_pos: assert property (O_TX_VALID && O_TX_LAST |-> sent_reg == 4'hd)
        else $error("last flag misplaced");
    a_tx_frame_end: assert property (O_TX_VALID && O_TX_LAST && I_TX_READY |=> !O_TX_VALID)
        else $error("frame runs on");
    a_preset_needs_still: assert property (O_PRESET_START |-> I_STANDSTILL_OK &&
        ((I_PARAM_ENABLE && !$past(I_PARAM_ENABLE)) || (O_CTRL_ONE[0] && !$past(O_CTRL_ONE[0]))))
        else $error("preset without request edge");
    a_preset_single: assert property (O_PRESET_START |=> !O_PRESET_START)
        else $error("preset started twice");
    a_ctrl_word_load: assert property ((I_RX_VALID && I_RX_SOF) ##1 (I_RX_VALID && !I_RX_SOF)
        |=> O_CTRL_ONE == {$past(I_RX_DATA, 2), $past(I_RX_DATA)})
        else $error("control word order");
    a_done_pulse: assert property (O_RX_FRAME_DONE |=> !O_RX_FRAME_DONE)
        else $error("done not a pulse");
endmodule // enc_frame_asserts

bind enc_frame enc_frame_asserts chk (.I_CLK, .I_RST_B, .I_STANDSTILL_OK, .I_PARAM_ENABLE,
    .O_PRESET_START,
    .I_RX_VALID, .I_RX_SOF, .I_RX_DATA, .O_CTRL_ONE, .O_RX_FRAME_DONE, .I_TX_START,
    .I_TX_READY, .O_TX_VALID, .O_TX_DATA, .O_TX_LAST);

// ---- verification/host_model.sv ----
// host side model: sends output frames, collects input frame bytes
// assumes byte streams on the framer's clock
module host_model
(
    // clock
    input wire logic clk,
    // output frame to the device
    output logic rx_valid,
    output logic rx_sof,
    output logic [7:0] rx_data,
    // input frame from the device
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic slow;
    initial
    begin
        {rx_valid, rx_sof, rx_data, tx_ready, slow} = 12'h000;
    end
    // stalling every other cycle makes the device hold each byte
    always @(posedge clk)
    begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    task automatic send(input logic [95:0] frame);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_data <= frame[95 - 8 * i -: 8];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule // host_model

// ---- verification/tb.sv ----
// self-checking bench for the process data framer
// assumes the host model drives both byte streams
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, still, en, done, tx_start, rx_v, rx_s, rx_done, tx_v, tx_r;
    logic [7:0] rx_d, tx_d, safe_ctl;
    logic [23:0] count, rx_chk;
    logic [15:0] ctrl1, ctrl2, p_turn, p_pos;
    logic [23:0] cnt_tab[6] = '{24'h0003e8, 24'h009c40, 24'h007fff, 24'hff63c0, 24'hff8000,
        24'hfffffb};
    logic [15:0] spd_tab[6] = '{16'h03e8, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 16'hfffb};
    logic [5:0] ovf_tab = 6'b001010;
    int fail_count = 0;
    int comparisons = 0;
    int starts = 0;
    logic p_start;
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    enc_frame uut (.I_CLK(clk), .I_RST_B(rst_b), .I_INCR_COUNT(count), .I_TURN_COUNT(16'h0005),
        .I_IN_TURN_POS(16'h1fff), .I_STANDSTILL_OK(still), .I_PARAM_ENABLE(en),
        .O_PRESET_START(p_start), .O_PRESET_TURN(p_turn), .O_PRESET_POS(p_pos),
        .I_PRESET_DONE(done),
        .I_RX_VALID(rx_v), .I_RX_SOF(rx_s), .I_RX_DATA(rx_d), .O_CTRL_ONE(ctrl1),
        .O_CTRL_TWO(ctrl2), .O_SAFE_CONTROL(safe_ctl), .O_RX_CHECK(rx_chk),
        .O_RX_FRAME_DONE(rx_done), .I_TX_START(tx_start), .I_TX_CHECK(24'habcdef),
        .I_TX_READY(tx_r), .O_TX_VALID(tx_v), .O_TX_DATA(tx_d), .O_TX_LAST());
    host_model host (.clk(clk), .rx_valid(rx_v), .rx_sof(rx_s), .rx_data(rx_d),
        .tx_valid(tx_v), .tx_data(tx_d), .tx_ready(tx_r));
    // accepted presets, counted at the edges where the device samples them
    always @(posedge clk)
        if (p_start === 1'b1)
            starts++;
    // ====================
    // shared tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] cam, st, spd, input logic [7:0] ss);
        logic [111:0] exp;
        logic [23:0] pos;
        exp = {cam, st, spd, 16'h0005, 16'h1fff, ss, 24'habcdef};
        host.got.delete();
        tx_start <= 1'b1;
        tick(1);
        tx_start <= 1'b0;
        for (int i = 0; i < 100 && host.got.size() < 14; i++)
            tick(1);
        chk(24'(host.got.size()), 24'd14);
        if (host.got.size() != 14)
            print_verdict();
        else
        begin
            for (int i = 0; i < 14; i++)
                chk(host.got[i], exp[111 - 8 * i -: 8]);
            // the host rebuilds the absolute position: 5 turns and 8191 steps
            pos = 24'({host.got[6], host.got[7]} * 8192 + {host.got[8], host.got[9]});
            chk(pos, 24'h00bfff);
        end
    endtask
    task automatic wr(input logic [15:0] c1, c2);
        host.send({c1, c2, 16'h3456, 16'h789a, 8'hbc, 24'hdef012});
        #1;
        chk(rx_done, 1'b1);
        chk({ctrl1, safe_ctl}, {c1, 8'hbc});
        chk({ctrl2, 8'h00}, {c2, 8'h00});
        chk({p_turn, 8'h00}, 24'h345600);
        chk({p_pos, 8'h00}, 24'h789a00);
        chk(rx_chk, 24'hdef012);
    endtask
    // ====================
    // main sequence
    initial
    begin
        {rst_b, still, en, done, tx_start} = 5'h00;
        count = 24'h000000;
        tick(4);
        rst_b <= 1'b1;
        wr(16'h1200, 16'h0000);
        for (int k = 0; k < 6; k++)
        begin
            count <= cnt_tab[k];
            host.slow <= k[0];
            tick(3);
            rd({15'h0000, ovf_tab[k]}, 16'h0000, spd_tab[k], 8'h00);
        end
        en <= 1'b1;
        tick(3);
        rd(16'h0000, 16'h8000, 16'hfffb, 8'h00);
        en <= 1'b0;
        tick(3);
        rd(16'h0000, 16'h0000, 16'hfffb, 8'h00);
        still <= 1'b1;
        wr(16'h0001, 16'h0001);
        tick(3);
        rd(16'h0000, 16'h0001, 16'h0005, 8'h00);
        done <= 1'b1;
        tick(1);
        done <= 1'b0;
        tick(2);
        rd(16'h0000, 16'h0000, 16'h0005, 8'h01);
        chk(24'(starts), 24'd1);
        print_verdict();
    end
endmodule // tb
